// *** bench/zc_fetch_model.sv ***
// fetch side model: issues what the bench asks, follows redirects
`timescale 1ns/100ps
module zc_fetch_model (
	input wire logic            mclk_in,
	input wire logic            rst_n_in,
	input zc_link_pkg::issue_t  req_in,
	input zc_link_pkg::result_t result_in,
	output zc_link_pkg::issue_t issue_out
);
	logic [31:0] pc_q;
	logic [31:0] pc_d;
	// slot contents and sources only as the bench commands
	assign issue_out = '{req_in.valid, pc_q, req_in.insn, req_in.src_value, req_in.is_xfer};
	always_comb pc_d = result_in.redirect ? result_in.target : pc_q + (req_in.valid ? 32'h4 : 32'h0);
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) pc_q <= 32'h1000;
		else pc_q <= pc_d;
	end
endmodule : zc_fetch_model

// *** bench/zc_link_props.sv ***
// checker for the zero-compare branch-and-link unit
`timescale 1ns/100ps
module zc_link_props (
	input wire logic            mclk_in,
	input wire logic            rst_n_in,
	input zc_link_pkg::issue_t  issue_in,
	input wire logic            slot_fault_in,
	input zc_link_pkg::result_t result_out,
	input wire logic            branch_hit_out,
	input wire logic            in_delay_slot_out,
	input wire logic            in_forbidden_slot_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	// a branch word inside a slot is a slot instruction, not a new branch
	wire        idle = !in_delay_slot_out && !in_forbidden_slot_out;
	wire        leg = idle && issue_in.valid && branch_hit_out && issue_in.insn[31:26] == 6'h01;
	wire        cmp = idle && issue_in.valid && branch_hit_out && issue_in.insn[31:26] != 6'h01;
	wire [31:0] off = {{14{issue_in.insn[15]}}, issue_in.insn[15:0], 2'h0};
	chk_link_reg_fixed: assert property (result_out.link_we |-> result_out.link_reg == 5'h1F)
		else $error("link reg");
	chk_compact_link: assert property (cmp |=> result_out.link_we && result_out.link_value == $past(issue_in.pc) + 32'h4)
		else $error("compact link");
	chk_legacy_link: assert property (leg |=> result_out.link_we && result_out.link_value == $past(issue_in.pc) + 32'h8)
		else $error("legacy link");
	chk_compact_target: assert property (cmp |=> !result_out.redirect || result_out.target == $past(issue_in.pc + off) + 32'h4)
		else $error("compact target");
	chk_legacy_slot: assert property (leg |=> in_delay_slot_out && !result_out.redirect)
		else $error("delay slot");
	chk_refuse_other: assert property (issue_in.valid && !branch_hit_out && !in_delay_slot_out && !in_forbidden_slot_out |=> !result_out.valid)
		else $error("stray result");
	chk_forbid_trap: assert property (in_forbidden_slot_out && issue_in.valid && issue_in.is_xfer && !slot_fault_in |=> result_out.reserved_trap)
		else $error("no trap");
	chk_taken_no_slot: assert property (result_out.redirect && result_out.link_we |-> !in_forbidden_slot_out)
		else $error("slot after taken");
	cov_taken: cover property (cmp ##1 result_out.redirect);
	cov_trap: cover property (result_out.reserved_trap);
	cov_delay: cover property (in_delay_slot_out && issue_in.valid);
endmodule : zc_link_props

bind zc_link_unit zc_link_props props (.mclk_in, .rst_n_in, .issue_in, .slot_fault_in, .result_out,
	.branch_hit_out, .in_delay_slot_out, .in_forbidden_slot_out);

// *** bench/zc_link_unit_tb_top.sv ***
// self-checking bench for the zero-compare branch-and-link unit
`timescale 1ns/100ps
module zc_link_unit_tb_top;
	logic                 mclk_in = 1'h0;
	logic                 rst_n_in = 1'h0;
	logic                 fault = 1'h0;
	logic                 hit;
	logic                 dslot;
	logic                 fslot;
	logic [31:0]          p;
	int                   failures = 0;
	int                   n_checks = 0;
	zc_link_pkg::issue_t  rq = '0;
	zc_link_pkg::issue_t  iss;
	zc_link_pkg::result_t res;
	zc_link_pkg::result_t res_leg;
	logic                 dslot_leg;
	always #50 mclk_in = ~mclk_in;
	zc_fetch_model fm (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .req_in(rq), .result_in(res), .issue_out(iss));
	zc_link_unit dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .issue_in(iss), .slot_fault_in(fault),
		.result_out(res), .branch_hit_out(hit), .in_delay_slot_out(dslot), .in_forbidden_slot_out(fslot));
	// second copy with the legacy conditional form kept, fed the same stream
	zc_link_unit #(.LEGACY_EN(1'b1)) dut_legacy (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .issue_in(iss),
		.slot_fault_in(fault), .result_out(res_leg), .branch_hit_out(), .in_delay_slot_out(dslot_leg),
		.in_forbidden_slot_out());
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic end_of_test;
		if (failures == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_of_test
	task automatic put(input logic v, input logic [31:0] i, input logic [31:0] s, input logic c);
		@(posedge mclk_in);
		#1;
		rq = '{v, 32'h0, i, s, c};
	endtask : put
	task automatic t_compact;
		logic [43:0] tab [6] = '{{6'h06, 5'h00, 32'h0, 1'h1}, {6'h06, 5'h03, 32'hFFFF_FFFF, 1'h0},
			{6'h07, 5'h00, 32'h1, 1'h1}, {6'h07, 5'h03, 32'h0, 1'h0}, {6'h08, 5'h00, 32'h5, 1'h0},
			{6'h18, 5'h00, 32'h5, 1'h1}};
		foreach (tab[k]) begin
			put(1'h1, {tab[k][43:33], 5'h03, 16'hFFFE}, tab[k][32:1], 1'h0);
			p = iss.pc;
			#1;
			chk(32'(hit), 32'h1, "hit");
			// a taken branch skips its next word, so nothing is issued there
			put(!tab[k][0], 32'h0800_0000, 32'h0, 1'h1);
			chk(32'(res.link_we), 32'h1, "link_we");
			chk(res.link_value, p + 32'h4, "link");
			chk(32'(res.redirect), 32'(tab[k][0]), "taken");
			chk(32'(fslot), 32'(!tab[k][0]), "forbidden");
			if (tab[k][0]) chk(res.target, p - 32'h4, "target");
			put(1'h0, 32'h0, 32'h0, 1'h0);
			chk(32'(res.reserved_trap), 32'(!tab[k][0]), "trap");
			if (!tab[k][0]) chk(res.restart_pc, p, "restart");
		end
	endtask : t_compact
	task automatic t_legacy_call;
		put(1'h1, 32'h0411_0003, 32'h8000_0000, 1'h0);
		p = iss.pc;
		put(1'h1, 32'h0, 32'h0, 1'h0);
		chk(res.link_value, p + 32'h8, "link");
		chk(32'(dslot), 32'h1, "delay slot");
		put(1'h1, 32'h0411_0003, 32'h0, 1'h0);
		chk(32'(res.redirect), 32'h1, "call");
		chk(res.target, p + 32'h10, "target");
		p = iss.pc;
		put(1'h1, 32'h0, 32'h0, 1'h0);
		fault = 1'h1;
		put(1'h0, 32'h0, 32'h0, 1'h0);
		fault = 1'h0;
		chk(32'(res.redirect), 32'h0, "faulted jump");
		chk(res.restart_pc, p, "restart");
	endtask : t_legacy_call
	task automatic t_refused;
		logic [31:0] sv [2] = '{32'h1, 32'h8000_0000};
		foreach (sv[k]) begin
			put(1'h1, 32'h04B1_0001, sv[k], 1'h0);
			p = iss.pc;
			// hit is combinational from the word just driven
			#1;
			chk(32'(hit), 32'h0, "hit");
			put(1'h1, 32'h0, 32'h0, 1'h0);
			chk(32'(res.valid), 32'h0, "valid");
			chk(32'(dslot_leg), 32'h1, "legacy slot");
			chk(res_leg.link_value, p + 32'h8, "legacy link");
			put(1'h0, 32'h0, 32'h0, 1'h0);
			chk(32'(res_leg.redirect), 32'(!sv[k][31]), "legacy taken");
			if (!sv[k][31]) chk(res_leg.target, p + 32'h8, "legacy target");
		end
	endtask : t_refused
	task automatic t_reset;
		put(1'h1, 32'h1803_0000, 32'h1, 1'h0);
		put(1'h0, 32'h0, 32'h0, 1'h0);
		chk(32'(fslot), 32'h1, "forbidden");
		rst_n_in = 1'h0;
		#1;
		chk(32'(fslot), 32'h0, "reset slot");
		chk(32'(res.link_we), 32'h0, "reset link");
		repeat (2) @(posedge mclk_in);
		#1;
		rst_n_in = 1'h1;
		put(1'h1, 32'h0800_0000, 32'h0, 1'h1);
		put(1'h0, 32'h0, 32'h0, 1'h0);
		chk(32'(res.reserved_trap), 32'h0, "stale trap");
	endtask : t_reset
	initial begin
		repeat (6) @(posedge mclk_in);
		#1;
		rst_n_in = 1'h1;
		t_compact();
		t_legacy_call();
		t_refused();
		t_reset();
		end_of_test();
	end
endmodule : zc_link_unit_tb_top

// *** hw/zc_cond_eval.sv ***
// signed compare of one register value against zero
`timescale 1ns/100ps
module zc_cond_eval #(
	parameter int W = 32
) (
	input  zc_link_pkg::cond_t cond_in,
	input  wire logic [W-1:0]  value_in,
	output logic               taken_out
);
	logic neg;
	logic zero;
	assign neg  = value_in[W-1];
	assign zero = (value_in == '0);

	always_comb begin
		case (cond_in)
			zc_link_pkg::COND_GEZ:  taken_out = !neg;
			zc_link_pkg::COND_LEZ:  taken_out = neg || zero;
			zc_link_pkg::COND_GTZ:  taken_out = !neg && !zero;
			zc_link_pkg::COND_LTZ:  taken_out = neg;
			zc_link_pkg::COND_EQZ:  taken_out = zero;
			zc_link_pkg::COND_NEZ:  taken_out = !zero;
			zc_link_pkg::COND_ALW:  taken_out = 1'b1;
			default:                taken_out = 1'b0;
		endcase
	end
endmodule : zc_cond_eval

// *** hw/zc_decode.sv ***
// field decode of the zero-compare branch-and-link encodings
`timescale 1ns/100ps
module zc_decode #(
	parameter bit LEGACY_EN = 1'b0
) (
	input  wire logic [31:0]       insn_in,
	output zc_link_pkg::cond_t     cond_out,
	output logic                   compact_out,
	output logic                   delayed_out
);
	logic [5:0] opc;
	logic [4:0] fs;
	logic [4:0] ss;
	assign opc = insn_in[zc_link_pkg::OPC_HI:zc_link_pkg::OPC_LO];
	assign fs  = insn_in[zc_link_pkg::FS_HI:zc_link_pkg::FS_LO];
	assign ss  = insn_in[zc_link_pkg::SS_HI:zc_link_pkg::SS_LO];

	always_comb begin
		cond_out    = zc_link_pkg::COND_NONE;
		compact_out = 1'b0;
		delayed_out = 1'b0;
		if (opc == zc_link_pkg::OP_REG_IMM && ss == zc_link_pkg::SS_NONNEG_LNK) begin
			if (fs == zc_link_pkg::ZERO_REG) begin
				cond_out    = zc_link_pkg::COND_ALW;
				delayed_out = 1'b1;
			end else if (LEGACY_EN) begin
				cond_out    = zc_link_pkg::COND_GEZ;
				delayed_out = 1'b1;
			end
		end else if (ss != zc_link_pkg::ZERO_REG) begin
			case (opc)
				zc_link_pkg::OP_GROUP6: begin
					if (fs == zc_link_pkg::ZERO_REG)
						cond_out = zc_link_pkg::COND_LEZ;
					else if (fs == ss)
						cond_out = zc_link_pkg::COND_GEZ;
				end
				zc_link_pkg::OP_GROUP7: begin
					if (fs == zc_link_pkg::ZERO_REG)
						cond_out = zc_link_pkg::COND_GTZ;
					else if (fs == ss)
						cond_out = zc_link_pkg::COND_LTZ;
				end
				zc_link_pkg::OP_GROUP8: begin
					if (fs == zc_link_pkg::ZERO_REG)
						cond_out = zc_link_pkg::COND_EQZ;
				end
				zc_link_pkg::OP_GROUP24: begin
					if (fs == zc_link_pkg::ZERO_REG)
						cond_out = zc_link_pkg::COND_NEZ;
				end
				default: cond_out = zc_link_pkg::COND_NONE;
			endcase
			compact_out = (cond_out != zc_link_pkg::COND_NONE);
		end
	end
endmodule : zc_decode

// *** hw/zc_link_pkg.sv ***
// shared constants and carriers for the zero-compare branch-and-link unit
package zc_link_pkg;
	localparam int          WORD_W        = 32;
	localparam logic [5:0]  OP_REG_IMM    = 6'h01;
	localparam logic [4:0]  SS_NONNEG_LNK = 5'h11;
	localparam logic [5:0]  OP_GROUP6     = 6'h06;
	localparam logic [5:0]  OP_GROUP7     = 6'h07;
	localparam logic [5:0]  OP_GROUP8     = 6'h08;
	localparam logic [5:0]  OP_GROUP24    = 6'h18;
	localparam logic [4:0]  LINK_REG      = 5'h1F;
	localparam logic [4:0]  ZERO_REG      = 5'h00;
	localparam int          OPC_HI        = 31;
	localparam int          OPC_LO        = 26;
	localparam int          FS_HI         = 25;
	localparam int          FS_LO         = 21;
	localparam int          SS_HI         = 20;
	localparam int          SS_LO         = 16;
	localparam int          OFF_HI        = 15;
	localparam logic [31:0] INSN_BYTES    = 32'h0000_0004;
	localparam logic [31:0] PC_RESET      = 32'h0000_0000;

	typedef enum logic [2:0] {
		COND_NONE = 3'h0,
		COND_GEZ  = 3'h1,
		COND_LEZ  = 3'h2,
		COND_GTZ  = 3'h3,
		COND_LTZ  = 3'h4,
		COND_EQZ  = 3'h5,
		COND_NEZ  = 3'h6,
		COND_ALW  = 3'h7
	} cond_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] pc;
		logic [31:0] insn;
		logic [31:0] src_value;
		logic        is_xfer;
	} issue_t;

	typedef struct packed {
		logic        valid;
		logic        link_we;
		logic [4:0]  link_reg;
		logic [31:0] link_value;
		logic        redirect;
		logic [31:0] target;
		logic        reserved_trap;
		logic [31:0] restart_pc;
	} result_t;
endpackage : zc_link_pkg

// *** hw/zc_link_unit.sv ***
// decode and execute of the zero-compare branch-and-link instructions
`timescale 1ns/100ps
module zc_link_unit #(
	parameter bit LEGACY_EN = 1'b0
) (
	input  wire logic                   mclk_in,
	input  wire logic                   rst_n_in,
	input  zc_link_pkg::issue_t         issue_in,
	input  wire logic                   slot_fault_in,
	output zc_link_pkg::result_t        result_out,
	output logic                        branch_hit_out,
	output logic                        in_delay_slot_out,
	output logic                        in_forbidden_slot_out
);
	zc_link_pkg::cond_t cond;
	logic               compact;
	logic               delayed;
	logic               taken;
	logic [31:0]        offset_ext;
	logic [31:0]        next_pc;

	typedef enum logic [1:0] {
		SLOT_IDLE      = 2'b00,
		SLOT_DELAY     = 2'b01,
		SLOT_FORBIDDEN = 2'b11
	} slot_t;

	slot_t                slot_q;
	slot_t                slot_d;
	logic [31:0]          branch_pc_q;
	logic [31:0]          branch_pc_d;
	logic [31:0]          pend_target_q;
	logic [31:0]          pend_target_d;
	logic                 pend_taken_q;
	logic                 pend_taken_d;
	zc_link_pkg::result_t res_q;
	zc_link_pkg::result_t res_d;

	zc_decode #(
		.LEGACY_EN   (LEGACY_EN)
	) u_decode (
		.insn_in     (issue_in.insn),
		.cond_out    (cond),
		.compact_out (compact),
		.delayed_out (delayed)
	);

	zc_cond_eval #(
		.W         (zc_link_pkg::WORD_W)
	) u_eval (
		.cond_in   (cond),
		.value_in  (issue_in.src_value),
		.taken_out (taken)
	);

	// offset scaled by four then sign-extended from 18 bits
	assign offset_ext = {{14{issue_in.insn[zc_link_pkg::OFF_HI]}}, issue_in.insn[15:0], 2'b00};
	assign next_pc    = issue_in.pc + zc_link_pkg::INSN_BYTES;

	assign branch_hit_out        = issue_in.valid && (cond != zc_link_pkg::COND_NONE);
	assign in_delay_slot_out     = (slot_q == SLOT_DELAY);
	assign in_forbidden_slot_out = (slot_q == SLOT_FORBIDDEN);
	assign result_out            = res_q;

	always_comb begin
		slot_d        = slot_q;
		branch_pc_d   = branch_pc_q;
		pend_target_d = pend_target_q;
		pend_taken_d  = pend_taken_q;
		res_d         = '0;
		res_d.link_reg = zc_link_pkg::LINK_REG;
		if (issue_in.valid) begin
			case (slot_q)
				SLOT_DELAY: begin
					// slot instruction runs first, then the held redirect lands
					res_d.valid    = 1'b1;
					res_d.redirect = pend_taken_q;
					res_d.target   = pend_target_q;
					if (slot_fault_in) begin
						res_d.redirect   = 1'b0;
						res_d.restart_pc = branch_pc_q;
					end
					slot_d = SLOT_IDLE;
				end
				SLOT_FORBIDDEN: begin
					// only reached when the compact branch fell through
					res_d.valid = 1'b1;
					if (issue_in.is_xfer) begin
						res_d.reserved_trap = 1'b1;
						res_d.restart_pc    = branch_pc_q;
					end else if (slot_fault_in) begin
						res_d.restart_pc = branch_pc_q;
					end
					slot_d = SLOT_IDLE;
				end
				default: begin
					if (cond != zc_link_pkg::COND_NONE) begin
						res_d.valid   = 1'b1;
						res_d.link_we = 1'b1;
						branch_pc_d   = issue_in.pc;
						pend_target_d = next_pc + offset_ext;
						if (delayed) begin
							res_d.link_value = next_pc + zc_link_pkg::INSN_BYTES;
							pend_taken_d     = taken;
							slot_d           = SLOT_DELAY;
						end else if (compact) begin
							res_d.link_value = next_pc;
							res_d.redirect   = taken;
							res_d.target     = next_pc + offset_ext;
							pend_taken_d     = 1'b0;
							slot_d           = taken ? SLOT_IDLE : SLOT_FORBIDDEN;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			slot_q        <= SLOT_IDLE;
			branch_pc_q   <= zc_link_pkg::PC_RESET;
			pend_target_q <= zc_link_pkg::PC_RESET;
			pend_taken_q  <= 1'b0;
			res_q         <= '0;
		end else begin
			slot_q        <= slot_d;
			branch_pc_q   <= branch_pc_d;
			pend_target_q <= pend_target_d;
			pend_taken_q  <= pend_taken_d;
			res_q         <= res_d;
		end
	end
endmodule : zc_link_unit
